// ---- verilog/crfrg_pkg.sv ----
// constants shared by the receive-queue release guard
// assumes one system clock; register port is 8-bit address and data
package crfrg_pkg;
  // register offsets
  localparam logic [7:0] OFS_QCTRL0  = 8'h00; // receive_queue_ctrl, queue 0
  localparam logic [7:0] OFS_QCTRL1  = 8'h01; // receive_queue_ctrl, queue 1
  localparam logic [7:0] OFS_STATE   = 8'h02; // cell_state_reg
  localparam logic [7:0] OFS_DIAG    = 8'h03; // diagnostic_reg
  localparam logic [7:0] OFS_BITTIME = 8'h04; // cycles per bus bit
  localparam logic [7:0] OFS_SAMPLE  = 8'h05; // cycles from bit start to sample
  localparam logic [7:0] OFS_ISTAT   = 8'h06; // sticky event flags
  localparam logic [7:0] OFS_IMASK   = 8'h07; // event mask
  localparam logic [7:0] OFS_HEAD0   = 8'h08; // oldest message, queue 0
  localparam logic [7:0] OFS_HEAD1   = 8'h09; // oldest message, queue 1
  // field positions
  localparam int unsigned BIT_FAULT   = 2; // queue pointer fault, read only
  localparam int unsigned BIT_RELEASE = 5; // release trigger, reads 0
  localparam int unsigned BIT_RECV    = 5; // receiving_flag in cell_state_reg
  localparam int unsigned BIT_RXLINE  = 3; // receive line in diagnostic_reg
  // event flag positions
  localparam int unsigned EV_STORED0 = 0;
  localparam int unsigned EV_STORED1 = 1;
  localparam int unsigned EV_OVR0    = 2;
  localparam int unsigned EV_OVR1    = 3;
  localparam int unsigned EV_FAULT0  = 4;
  localparam int unsigned EV_FAULT1  = 5;
  localparam int unsigned EV_W       = 6;
  // queue shape
  localparam logic [1:0] Q_LAST     = 2'h2; // slots 0..2
  localparam logic [1:0] Q_FULL     = 2'h3; // three pending
  localparam logic [1:0] Q_CRITICAL = 2'h2; // count at which the defect bites
  // transfer timing
  localparam logic [11:0] XFER_BITS = 12'h006; // full bits after acknowledge
  // reset values
  localparam logic [7:0] RST_BITTIME = 8'h14; // 20 cycles: 1 Mbit/s at 20 MHz
  localparam logic [7:0] RST_SAMPLE  = 8'h0E;
  localparam logic [7:0] RST_MASK    = 8'h00;
endpackage

// ---- verilog/crfrg_queue.sv ----
// one three-slot receive queue, with the release/transfer collision defect
// assumes one-cycle release and transfer pulses from the parent
`timescale 1ns/1ps
module crfrg_queue (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_xfer,
  input  wire logic [7:0] i_xfer_data,
  input  wire logic       i_release,
  output logic      [1:0] o_count,
  output logic      [7:0] o_head,
  output logic            o_fault,
  output logic            o_stored,
  output logic            o_overrun,
  output logic            o_collide
);
  logic [7:0] slot_r [0:2];
  logic [1:0] rd_ptr_r;
  logic [1:0] wr_ptr_r;
  logic [1:0] cnt_r;
  logic       fault_r;
  logic       accept;
  logic       rel_ok;
  logic       collide;
  logic [1:0] wr_idx;

  function automatic logic [1:0] inc(input logic [1:0] p);
    inc = (p == crfrg_pkg::Q_LAST) ? 2'h0 : p + 2'h1;
  endfunction

  // request qualification and collision detect
  assign accept  = i_xfer && (cnt_r != crfrg_pkg::Q_FULL);
  assign rel_ok  = i_release && (cnt_r != 2'h0);
  assign collide = accept && rel_ok && (cnt_r == crfrg_pkg::Q_CRITICAL);
  // after the fault new data lands on the newest slot
  assign wr_idx  = fault_r ? ((wr_ptr_r == 2'h0) ? crfrg_pkg::Q_LAST : wr_ptr_r - 2'h1)
                           : wr_ptr_r;

  // message storage
  always_ff @(posedge i_sys_clk) begin
    if (accept) begin
      slot_r[wr_idx] <= i_xfer_data;
    end
  end

  // pointers: read pointer stalls on a collision
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rd_ptr_r <= 2'h0;
      wr_ptr_r <= 2'h0;
    end else begin
      if (rel_ok && !collide) begin
        rd_ptr_r <= inc(rd_ptr_r);
      end
      if (accept && !fault_r) begin
        wr_ptr_r <= inc(wr_ptr_r);
      end
    end
  end

  // pending count: a collision counts the release although the read pointer stalls
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_r <= 2'h0;
    end else if (accept && !rel_ok) begin
      cnt_r <= cnt_r + 2'h1;
    end else if (rel_ok && !accept) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  // fault stays until reset
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fault_r <= 1'b0;
    end else if (collide) begin
      fault_r <= 1'b1;
    end
  end

  assign o_count   = cnt_r;
  assign o_head    = slot_r[rd_ptr_r];
  assign o_fault   = fault_r;
  assign o_stored  = accept;
  assign o_overrun = i_xfer && !accept;
  assign o_collide = collide;

  property p_fault_sticky;
    @(posedge i_sys_clk) disable iff (i_reset) fault_r |=> fault_r;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared");

  property p_ptr_hold;
    @(posedge i_sys_clk) disable iff (i_reset) collide |=> rd_ptr_r == $past(rd_ptr_r);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("read pointer moved");

  property p_count_ok;
    @(posedge i_sys_clk) disable iff (i_reset)
      collide |=> cnt_r == crfrg_pkg::Q_CRITICAL && fault_r;
  endproperty
  a_count_ok: assert property (p_count_ok) else $error("count wrong on collision");

  property p_overwrite;
    @(posedge i_sys_clk) disable iff (i_reset)
      fault_r && accept |=> wr_ptr_r == $past(wr_ptr_r);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("write pointer moved in fault");

  c_collide: cover property (@(posedge i_sys_clk) disable iff (i_reset) collide);
endmodule // crfrg_queue

// ---- verilog/crfrg_top.sv ----
// receive-queue release path of one controller cell, two queues
// assumes frames handed over by the protocol engine, inputs synchronous
`timescale 1ns/1ps
module crfrg_top (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic       i_receiving,
  input  wire logic       i_rx_line,
  input  wire logic       i_ack_done,
  input  wire logic [7:0] i_frame_data,
  input  wire logic       i_frame_queue,
  output logic      [7:0] o_rd_data,
  output logic            o_irq
);
  typedef enum logic { CRFRG_IDLE, CRFRG_WAIT } crfrg_state_t;

  crfrg_state_t                state_r;
  logic         [11:0]         wait_r;
  logic         [11:0]         wait_nxt;
  logic         [7:0]          data_hold_r;
  logic                        queue_hold_r;
  logic         [1:0]          xfer_r;
  logic         [1:0]          release_r;
  logic         [7:0]          bittime_r;
  logic         [7:0]          sample_r;
  logic                        recv_r;
  logic                        rxline_r;
  logic [crfrg_pkg::EV_W-1:0]  istat_r;
  logic [crfrg_pkg::EV_W-1:0]  imask_r;
  logic [crfrg_pkg::EV_W-1:0]  ev_set;
  logic [crfrg_pkg::EV_W-1:0]  ev_clr;
  logic         [7:0]          rd_data_r;
  logic         [7:0]          rd_nxt;
  logic                        irq_r;
  logic         [1:0]          q_count [0:1];
  logic         [7:0]          q_head  [0:1];
  logic         [1:0]          q_fault;
  logic         [1:0]          q_stored;
  logic         [1:0]          q_overrun;
  logic         [1:0]          q_collide;

  // two queues of the cell
  for (genvar q = 0; q < 2; q++) begin : g_queue
    crfrg_queue u_queue (
      .i_sys_clk   (i_sys_clk),
      .i_reset     (i_reset),
      .i_xfer      (xfer_r[q]),
      .i_xfer_data (data_hold_r),
      .i_release   (release_r[q]),
      .o_count     (q_count[q]),
      .o_head      (q_head[q]),
      .o_fault     (q_fault[q]),
      .o_stored    (q_stored[q]),
      .o_overrun   (q_overrun[q]),
      .o_collide   (q_collide[q])
    );
  end

  // wait from ack end to transfer point: six bits plus sample offset
  assign wait_nxt = 12'(crfrg_pkg::XFER_BITS * {4'h0, bittime_r}) + {4'h0, sample_r};

  // transfer timer
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r      <= CRFRG_IDLE;
      wait_r       <= 12'h000;
      data_hold_r  <= 8'h00;
      queue_hold_r <= 1'b0;
    end else begin
      case (state_r)
        CRFRG_IDLE: begin
          if (i_ack_done) begin
            state_r      <= CRFRG_WAIT;
            wait_r       <= wait_nxt;
            data_hold_r  <= i_frame_data;
            queue_hold_r <= i_frame_queue;
          end
        end
        CRFRG_WAIT: begin
          if (wait_r <= 12'h001) begin
            state_r <= CRFRG_IDLE;
          end else begin
            wait_r <= wait_r - 12'h001;
          end
        end
        default: begin
          state_r <= CRFRG_IDLE;
        end
      endcase
    end
  end

  // one-cycle transfer pulse at the end of the wait
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      xfer_r <= 2'h0;
    end else if (state_r == CRFRG_WAIT && wait_r <= 12'h001) begin
      xfer_r <= queue_hold_r ? 2'h2 : 2'h1;
    end else begin
      xfer_r <= 2'h0;
    end
  end

  // release trigger: one cycle, never stored
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      release_r <= 2'h0;
    end else begin
      release_r[0] <= i_wr_en && i_addr == crfrg_pkg::OFS_QCTRL0
                      && i_wr_data[crfrg_pkg::BIT_RELEASE];
      release_r[1] <= i_wr_en && i_addr == crfrg_pkg::OFS_QCTRL1
                      && i_wr_data[crfrg_pkg::BIT_RELEASE];
    end
  end

  // timing configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bittime_r <= crfrg_pkg::RST_BITTIME;
      sample_r  <= crfrg_pkg::RST_SAMPLE;
    end else if (i_wr_en) begin
      if (i_addr == crfrg_pkg::OFS_BITTIME) begin
        bittime_r <= i_wr_data;
      end
      if (i_addr == crfrg_pkg::OFS_SAMPLE) begin
        sample_r <= i_wr_data;
      end
    end
  end

  // reception status and line level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      recv_r   <= 1'b0;
      rxline_r <= 1'b1;
    end else begin
      recv_r   <= i_receiving;
      rxline_r <= i_rx_line;
    end
  end

  // event sources and write-one-to-clear
  assign ev_set = {q_collide[1], q_collide[0], q_overrun[1], q_overrun[0],
                   q_stored[1], q_stored[0]};
  assign ev_clr = (i_wr_en && i_addr == crfrg_pkg::OFS_ISTAT)
                  ? i_wr_data[crfrg_pkg::EV_W-1:0] : '0;

  // sticky flags: a set wins over a clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      istat_r <= '0;
    end else begin
      istat_r <= (istat_r & ~ev_clr) | ev_set;
    end
  end

  // event mask
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      imask_r <= crfrg_pkg::RST_MASK[crfrg_pkg::EV_W-1:0];
    end else if (i_wr_en && i_addr == crfrg_pkg::OFS_IMASK) begin
      imask_r <= i_wr_data[crfrg_pkg::EV_W-1:0];
    end
  end

  // interrupt level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = 8'h00;
    case (i_addr)
      crfrg_pkg::OFS_QCTRL0: begin
        rd_nxt[1:0] = q_count[0];
        rd_nxt[crfrg_pkg::BIT_FAULT] = q_fault[0];
      end
      crfrg_pkg::OFS_QCTRL1: begin
        rd_nxt[1:0] = q_count[1];
        rd_nxt[crfrg_pkg::BIT_FAULT] = q_fault[1];
      end
      crfrg_pkg::OFS_STATE:   rd_nxt[crfrg_pkg::BIT_RECV] = recv_r;
      crfrg_pkg::OFS_DIAG:    rd_nxt[crfrg_pkg::BIT_RXLINE] = rxline_r;
      crfrg_pkg::OFS_BITTIME: rd_nxt = bittime_r;
      crfrg_pkg::OFS_SAMPLE:  rd_nxt = sample_r;
      crfrg_pkg::OFS_ISTAT:   rd_nxt[crfrg_pkg::EV_W-1:0] = istat_r;
      crfrg_pkg::OFS_IMASK:   rd_nxt[crfrg_pkg::EV_W-1:0] = imask_r;
      crfrg_pkg::OFS_HEAD0:   rd_nxt = q_head[0];
      crfrg_pkg::OFS_HEAD1:   rd_nxt = q_head[1];
      default:                rd_nxt = 8'h00;
    endcase
  end

  // read data stand one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rd_data_r <= 8'h00;
    end else if (i_rd_en) begin
      rd_data_r <= rd_nxt;
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_irq     = irq_r;

  // helper: cycles since the last ack end while waiting
  logic [11:0] since_ack_r;
  logic [11:0] need_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      since_ack_r <= 12'h000;
      need_r      <= 12'h000;
    end else if (state_r == CRFRG_IDLE && i_ack_done) begin
      since_ack_r <= 12'h001;
      need_r      <= wait_nxt;
    end else if (since_ack_r != 12'hFFF) begin
      since_ack_r <= since_ack_r + 12'h001;
    end
  end

  property p_xfer_late;
    @(posedge i_sys_clk) disable iff (i_reset) |xfer_r |-> since_ack_r > need_r;
  endproperty
  a_xfer_late: assert property (p_xfer_late) else $error("transfer too early");

  property p_xfer_one;
    @(posedge i_sys_clk) disable iff (i_reset) |xfer_r |=> xfer_r == 2'h0;
  endproperty
  a_xfer_one: assert property (p_xfer_one) else $error("transfer over one cycle");

  property p_release_one;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_wr_en && i_addr == crfrg_pkg::OFS_QCTRL0 && i_wr_data[crfrg_pkg::BIT_RELEASE]
      ##1 !(i_wr_en && i_addr == crfrg_pkg::OFS_QCTRL0) |=> !release_r[0];
  endproperty
  a_release_one: assert property (p_release_one) else $error("release not cleared");

  property p_release_read0;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr == crfrg_pkg::OFS_QCTRL1 |=> !o_rd_data[crfrg_pkg::BIT_RELEASE];
  endproperty
  a_release_read0: assert property (p_release_read0) else $error("release read 1");

  property p_recv_bit;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr == crfrg_pkg::OFS_STATE
      |=> o_rd_data[crfrg_pkg::BIT_RECV] == $past(recv_r);
  endproperty
  a_recv_bit: assert property (p_recv_bit) else $error("receiving bit wrong");

  property p_count_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr == crfrg_pkg::OFS_QCTRL0 |=> o_rd_data[1:0] == $past(q_count[0]);
  endproperty
  a_count_read: assert property (p_count_read) else $error("pending count wrong");

  property p_irq_follow;
    @(posedge i_sys_clk) disable iff (i_reset)
      |(ev_set & imask_r) ##1 !$rose(i_reset) |=> o_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt missing");

  property p_rd_idle;
    @(posedge i_sys_clk) disable iff (i_reset) !i_rd_en |=> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");

  property p_unmapped;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr > crfrg_pkg::OFS_HEAD1 |=> o_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address read nonzero");

  property p_diag_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr == crfrg_pkg::OFS_DIAG
      |=> o_rd_data[crfrg_pkg::BIT_RXLINE] == $past(rxline_r);
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("receive line bit wrong");

  property p_fault_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr == crfrg_pkg::OFS_QCTRL0
      |=> o_rd_data[crfrg_pkg::BIT_FAULT] == $past(q_fault[0]);
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault bit wrong");

  property p_count_read1;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr == crfrg_pkg::OFS_QCTRL1 |=> o_rd_data[1:0] == $past(q_count[1]);
  endproperty
  a_count_read1: assert property (p_count_read1) else $error("pending count wrong");

  property p_head_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_rd_en && i_addr == crfrg_pkg::OFS_HEAD0 |=> o_rd_data == $past(q_head[0]);
  endproperty
  a_head_read: assert property (p_head_read) else $error("oldest message wrong");

  property p_set_wins;
    @(posedge i_sys_clk) disable iff (i_reset)
      |ev_set |=> (istat_r & $past(ev_set)) == $past(ev_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event flag lost");

  property p_w1c;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_wr_en && i_addr == crfrg_pkg::OFS_ISTAT && i_wr_data[0] && !ev_set[0]
      |=> !istat_r[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");

  property p_irq_level;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_irq == |($past(istat_r) & $past(imask_r));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_xfer_dest;
    @(posedge i_sys_clk) disable iff (i_reset)
      |xfer_r |-> $onehot(xfer_r) && xfer_r[1] == queue_hold_r;
  endproperty
  a_xfer_dest: assert property (p_xfer_dest) else $error("transfer to wrong queue");

  c_xfer: cover property (@(posedge i_sys_clk) disable iff (i_reset) |xfer_r);
  c_irq: cover property (@(posedge i_sys_clk) disable iff (i_reset) $rose(o_irq));
  c_release: cover property (@(posedge i_sys_clk) disable iff (i_reset) |release_r);
endmodule // crfrg_top

// ---- tb/crfrg_can_node.sv ----
// far-side model: protocol engine and bus as seen by the receive queues
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
module crfrg_can_node (
  input  wire logic       i_sys_clk,
  output logic            o_receiving,
  output logic            o_rx_line,
  output logic            o_ack_done,
  output logic      [7:0] o_frame_data,
  output logic            o_frame_queue
);
  // idle bus is recessive; payload lines outside a handover show the inverse
  initial begin
    o_receiving   = 1'h0;
    o_rx_line     = 1'h1;
    o_ack_done    = 1'h0;
    o_frame_data  = 8'h00;
    o_frame_queue = 1'h0;
  end

  // hold one bus bit for cyc clock cycles
  task automatic bus_bit(input logic lvl, input int cyc);
    o_rx_line <= lvl;
    repeat (cyc) @(posedge i_sys_clk);
  endtask

  // one frame: payload bits, dominant ack, then a recessive tail
  task automatic send_frame(input logic [7:0] data, input logic q, input int cyc);
    @(posedge i_sys_clk);
    o_receiving <= 1'h1;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(data[i], cyc);
    end
    bus_bit(1'h0, cyc);
    o_ack_done    <= 1'h1; // end of the acknowledge bit
    o_frame_data  <= data;
    o_frame_queue <= q;
    o_rx_line     <= 1'h1;
    @(posedge i_sys_clk);
    o_ack_done    <= 1'h0;
    o_frame_data  <= ~data;
    o_frame_queue <= ~q;
    repeat (8 * cyc - 1) @(posedge i_sys_clk);
    o_receiving <= 1'h0;
  endtask

  // park the reception flag and line at chosen levels
  task automatic set_lines(input logic receiving_flag, input logic line);
    @(posedge i_sys_clk);
    o_receiving <= receiving_flag;
    o_rx_line   <= line;
  endtask
endmodule // crfrg_can_node

// ---- tb/tb_top.sv ----
// self-checking bench for the receive-queue release guard
// assumes a 20 MHz clock and the far-side model crfrg_can_node
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  logic       i_sys_clk;
  logic       i_reset;
  logic [7:0] i_addr;
  logic [7:0] i_wr_data;
  logic       i_wr_en;
  logic       i_rd_en;
  logic       receiving;
  logic       rx_line;
  logic       ack_done;
  logic [7:0] frame_data;
  logic       frame_queue;
  logic [7:0] o_rd_data;
  logic       o_irq;
  logic [7:0] rd_val;
  int         error_cnt;
  int         check_count;
  int         hits;

  crfrg_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_receiving(receiving), .i_rx_line(rx_line), .i_ack_done(ack_done),
    .i_frame_data(frame_data), .i_frame_queue(frame_queue),
    .o_rd_data(o_rd_data), .o_irq(o_irq));

  crfrg_can_node node (.i_sys_clk(i_sys_clk), .o_receiving(receiving),
    .o_rx_line(rx_line), .o_ack_done(ack_done), .o_frame_data(frame_data),
    .o_frame_queue(frame_queue));

  // 50 ns clock
  initial begin
    i_sys_clk = 1'h0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // synchronous reset held for n cycles
  task automatic do_reset(input int n);
    i_reset <= 1'h1;
    repeat (n) @(posedge i_sys_clk);
    i_reset <= 1'h0;
    @(posedge i_sys_clk);
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr_en   <= 1'h1;
    @(posedge i_sys_clk);
    i_wr_en <= 1'h0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_rd_en <= 1'h1;
    @(posedge i_sys_clk);
    i_rd_en <= 1'h0;
    #1 rd_val = o_rd_data;
    @(posedge i_sys_clk); // hand back on an edge so the next stimulus lands on one
  endtask

  // returns at the edge that takes the handover
  task automatic wait_ack();
    int n;
    n = 0;
    while (ack_done !== 1'h1) begin
      @(posedge i_sys_clk);
      n++;
      if (n > 3000) begin
        error_cnt++;
        final_report();
      end
    end
  endtask

  // reset values, read-only bits and an unmapped address
  task automatic s_reset_values();
    rd(crfrg_pkg::OFS_BITTIME);
    `CHK(rd_val, crfrg_pkg::RST_BITTIME)
    rd(crfrg_pkg::OFS_SAMPLE);
    `CHK(rd_val, crfrg_pkg::RST_SAMPLE)
    rd(crfrg_pkg::OFS_IMASK);
    `CHK(rd_val, crfrg_pkg::RST_MASK)
    wr(crfrg_pkg::OFS_QCTRL0, 8'h07);
    rd(crfrg_pkg::OFS_QCTRL0);
    `CHK(rd_val, 8'h00)
    wr(8'h0F, 8'hFF);
    rd(8'h0F);
    `CHK(rd_val, 8'h00)
  endtask

  // queue 1 path: transfer delay, head, interrupt, release trigger
  task automatic s_q1_path();
    fork
      node.send_frame(8'hA5, 1'h1, 20);
      begin
        wait_ack();
        repeat (132) @(posedge i_sys_clk);
        rd(crfrg_pkg::OFS_QCTRL1);
        `CHK(rd_val, 8'h00)
        repeat (14) @(posedge i_sys_clk);
        rd(crfrg_pkg::OFS_QCTRL1);
        `CHK(rd_val, 8'h01)
      end
    join
    rd(crfrg_pkg::OFS_HEAD1);
    `CHK(rd_val, 8'hA5)
    rd(crfrg_pkg::OFS_QCTRL0);
    `CHK(rd_val, 8'h00)
    rd(crfrg_pkg::OFS_ISTAT);
    `CHK(rd_val, 8'h02)
    wr(crfrg_pkg::OFS_IMASK, 8'h01);
    repeat (2) @(posedge i_sys_clk);
    #1 `CHK(o_irq, 1'h0)
    wr(crfrg_pkg::OFS_IMASK, 8'h02);
    repeat (2) @(posedge i_sys_clk);
    #1 `CHK(o_irq, 1'h1)
    wr(crfrg_pkg::OFS_ISTAT, 8'h02);
    repeat (2) @(posedge i_sys_clk);
    #1 `CHK(o_irq, 1'h0)
    rd(crfrg_pkg::OFS_ISTAT);
    `CHK(rd_val, 8'h00)
    wr(crfrg_pkg::OFS_QCTRL1, 8'h20);
    rd(crfrg_pkg::OFS_QCTRL1);
    `CHK(rd_val, 8'h00)
    wr(crfrg_pkg::OFS_QCTRL1, 8'h20);
    rd(crfrg_pkg::OFS_QCTRL1);
    `CHK(rd_val, 8'h00)
  endtask

  // reception flag and receive line as seen by software
  task automatic s_state_lines();
    node.set_lines(1'h1, 1'h1);
    rd(crfrg_pkg::OFS_STATE);
    `CHK(rd_val & 8'h20, 8'h20)
    rd(crfrg_pkg::OFS_DIAG);
    `CHK(rd_val & 8'h08, 8'h08)
    node.set_lines(1'h0, 1'h0);
    rd(crfrg_pkg::OFS_STATE);
    `CHK(rd_val & 8'h20, 8'h00)
    rd(crfrg_pkg::OFS_DIAG);
    `CHK(rd_val & 8'h08, 8'h00)
  endtask

  // after a pointer fault: flag, event, traffic, then reset
  task automatic s_fault_sticky();
    rd(crfrg_pkg::OFS_ISTAT);
    `CHK(rd_val & 8'h10, 8'h10)
    rd(crfrg_pkg::OFS_HEAD0);
    `CHK(rd_val, 8'h11)
    wr(crfrg_pkg::OFS_QCTRL0, 8'h04);
    node.send_frame(8'h44, 1'h0, 2);
    rd(crfrg_pkg::OFS_QCTRL0);
    `CHK(rd_val, 8'h07)
    wr(crfrg_pkg::OFS_QCTRL0, 8'h20);
    wr(crfrg_pkg::OFS_QCTRL0, 8'h20);
    rd(crfrg_pkg::OFS_HEAD0);
    `CHK(rd_val, 8'h44)
    do_reset(2);
    rd(crfrg_pkg::OFS_QCTRL0);
    `CHK(rd_val, 8'h00)
  endtask

  // release swept across the transfer at two pending; one offset collides
  task automatic s_collision();
    hits = 0;
    for (int k = 6; k <= 20; k++) begin
      do_reset(2);
      wr(crfrg_pkg::OFS_BITTIME, 8'h02);
      wr(crfrg_pkg::OFS_SAMPLE, 8'h01);
      node.send_frame(8'h11, 1'h0, 2);
      node.send_frame(8'h22, 1'h0, 2);
      fork
        node.send_frame(8'h33, 1'h0, 2);
        begin
          wait_ack();
          repeat (k) @(posedge i_sys_clk);
          wr(crfrg_pkg::OFS_QCTRL0, 8'h20);
        end
      join
      rd(crfrg_pkg::OFS_QCTRL0);
      `CHK(rd_val[1:0], 2'h2)
      if (rd_val[2] === 1'h1) begin
        hits++;
        s_fault_sticky();
      end
    end
    `CHK(hits, 1)
  endtask

  // safe release: test the count, wait out the transfer point, release at once
  task automatic guarded_release(input logic [7:0] a);
    logic [7:0] ctrl;
    int         n;
    n = 0;
    rd(a);
    ctrl = rd_val;
    if ((ctrl & 8'h03) == 8'h02) begin
      while (n < 200) begin
        rd(crfrg_pkg::OFS_STATE);
        if (rd_val[5] !== 1'h1) begin
          break;
        end
        rd(crfrg_pkg::OFS_DIAG);
        if (rd_val[3] !== 1'h1) begin
          break;
        end
        n++;
      end
    end
    if (n >= 200) begin
      error_cnt++;
      final_report();
    end
    wr(a, ctrl | 8'h20);
  endtask

  // guarded release swept from mid-payload to past the end of the third frame: never corrupts
  task automatic s_guarded();
    for (int k = 10; k <= 40; k += 3) begin
      do_reset(2);
      wr(crfrg_pkg::OFS_BITTIME, 8'h02);
      wr(crfrg_pkg::OFS_SAMPLE, 8'h01);
      node.send_frame(8'h11, 1'h0, 2);
      node.send_frame(8'h22, 1'h0, 2);
      fork
        node.send_frame(8'h33, 1'h0, 2);
        begin
          repeat (k) @(posedge i_sys_clk);
          guarded_release(crfrg_pkg::OFS_QCTRL0);
        end
      join
      rd(crfrg_pkg::OFS_QCTRL0);
      `CHK(rd_val, 8'h02)
    end
  endtask

  // main sequence
  initial begin
    i_reset     = 1'h1;
    i_addr      = 8'h00;
    i_wr_data   = 8'h00;
    i_wr_en     = 1'h0;
    i_rd_en     = 1'h0;
    rd_val      = 8'h00;
    error_cnt   = 0;
    check_count = 0;
    do_reset(10);
    s_reset_values();
    s_q1_path();
    s_state_lines();
    s_collision();
    s_guarded();
    final_report();
  end
endmodule // tb_top
